// *** core/dma_seq_pkg.sv ***
// Shared constants and types for the DMA sequencer
package dma_seq_pkg;
  // Command space byte offsets on the endpoint AHB port
  localparam logic [7:0] CMD_HOST_ADDR = 8'h00;
  localparam logic [7:0] CMD_MODE = 8'h04;
  localparam logic [7:0] CMD_SIZE = 8'h08;
  localparam logic [7:0] CMD_START = 8'h0C;
  localparam logic [7:0] CMD_STATUS = 8'h10;
  localparam logic [7:0] CMD_CYCLES = 8'h14;
  localparam int CMD_AW = 8;

  // Status word fields
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_BAD = 2;

  // Field positions inside written command words
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 3;
  localparam int START_BIT = 0;

  // Sizes in bytes
  localparam int BYTES_W = 21;
  localparam logic [BYTES_W-1:0] SZ_16K = 21'h004000;
  localparam logic [BYTES_W-1:0] SZ_32K = 21'h008000;
  localparam logic [BYTES_W-1:0] SZ_64K = 21'h010000;
  localparam logic [BYTES_W-1:0] SZ_256K = 21'h040000;
  localparam logic [BYTES_W-1:0] SZ_1M = 21'h100000;
  localparam logic [BYTES_W-1:0] DESC_BYTES = SZ_64K;
  localparam int LEN_W = 17;

  // Fabric SRAM geometry
  localparam int SRAM_BYTES = 32768;
  localparam int SRAM_AW = 13;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Transfer direction as written to the mode command
  typedef enum logic [MODE_W-1:0] {
    DDR_TO_HOST, HOST_TO_DDR, SRAM_TO_DDR, DDR_TO_SRAM
  } xfer_e;

  // Size codes as written to the size command
  typedef enum logic [SIZE_W-1:0] {
    SIZE_64K, SIZE_256K, SIZE_1M, SIZE_16K, SIZE_32K, SIZE_R5, SIZE_R6, SIZE_R7
  } size_e;
endpackage

// *** core/sram_fifo_if.sv ***
// Valid/ready carrier for the write buffer in front of the fabric SRAM
`timescale 1ns/100ps
interface sram_fifo_if #(parameter int W = 45);
  logic inValid;
  logic inReady;
  logic [W-1:0] inData;
  logic outValid;
  logic outReady;
  logic [W-1:0] outData;
  modport fifo(input inValid, inData, outReady, output inReady, outValid, outData);
  modport user(output inValid, inData, outReady, input inReady, outValid, outData);
endinterface

// *** core/sync_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  sram_fifo_if.fifo port
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Depth must be a power of two so the pointers wrap naturally
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("sync_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign port.inReady = (count != (PW+1)'(DEPTH));
  assign port.outValid = (count != '0);
  assign port.outData = mem[rdPtr];
  assign push = port.inValid && port.inReady;
  assign pop = port.outValid && port.outReady;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= port.inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + PW'(1);
      end
      if (pop) begin
        rdPtr <= rdPtr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// *** core/pcie_ddr_dma_sequencer.sv ***
// Command decoder, descriptor sequencer, throughput timer and fabric SRAM
`timescale 1ns/100ps
module pcie_ddr_dma_sequencer #(
  parameter logic [31:0] DDR_BASE = 32'hA000_0000,
  parameter logic [31:0] SRAM_BASE = 32'h3000_0000,
  parameter int CYCLE_W = 32,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  // Command port from the endpoint acting as AHB master
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Setup toward the DMA engine
  output logic [31:0] engSrcAddr,
  output logic [31:0] engDstAddr,
  output logic [dma_seq_pkg::LEN_W-1:0] engLength,
  output logic [dma_seq_pkg::MODE_W-1:0] engMode,
  output logic engDescReset,
  output logic engStart,
  input wire logic engDone,
  // Fabric interface port into the fabric SRAM
  input wire logic fpWrValid,
  input wire logic [31:0] fpWrAddr,
  input wire logic [31:0] fpWrData,
  output logic fpWrReady,
  input wire logic fpRdValid,
  input wire logic [31:0] fpRdAddr,
  output logic fpRdReady,
  output logic fpRdDataValid,
  output logic [31:0] fpRdData,
  // Transfer state for the board
  output logic busy,
  output logic done
);
  localparam int FW = dma_seq_pkg::SRAM_AW + 32;

  generate
    if (CYCLE_W < 16 || CYCLE_W > 32 || FIFO_DEPTH < 2) begin : g_bad
      $error("pcie_ddr_dma_sequencer: unsupported parameter values");
    end
  endgenerate

  // Memory windows must be word aligned so every chunk starts on a word lane
  generate
    if (DDR_BASE[1:0] != 2'h0 || SRAM_BASE[1:0] != 2'h0) begin : g_align
      $error("pcie_ddr_dma_sequencer: base addresses must be word aligned");
    end
  endgenerate

  typedef enum {IDLE, LOAD, KICK, RUN, REARM, FINISH} seq_e;

  // Byte count for a size code, zero where the code is not legal for the direction
  function automatic logic [dma_seq_pkg::BYTES_W-1:0] sizeBytes(
      input dma_seq_pkg::xfer_e m, input dma_seq_pkg::size_e s);
    logic hostSide;
    hostSide = (m == dma_seq_pkg::DDR_TO_HOST) || (m == dma_seq_pkg::HOST_TO_DDR);
    sizeBytes = '0;
    if (hostSide) begin
      unique case (s)
        dma_seq_pkg::SIZE_64K: sizeBytes = dma_seq_pkg::SZ_64K;
        dma_seq_pkg::SIZE_256K: sizeBytes = dma_seq_pkg::SZ_256K;
        dma_seq_pkg::SIZE_1M: sizeBytes = dma_seq_pkg::SZ_1M;
        default: sizeBytes = '0;
      endcase
    end else begin
      unique case (s)
        dma_seq_pkg::SIZE_16K: sizeBytes = dma_seq_pkg::SZ_16K;
        dma_seq_pkg::SIZE_32K: sizeBytes = dma_seq_pkg::SZ_32K;
        default: sizeBytes = '0;
      endcase
    end
  endfunction

  seq_e state;
  logic [31:0] hostAddr;
  dma_seq_pkg::xfer_e mode;
  dma_seq_pkg::size_e sizeCode;
  logic [dma_seq_pkg::BYTES_W-1:0] remain;
  logic [dma_seq_pkg::BYTES_W-1:0] offset;
  logic [CYCLE_W-1:0] cycles;
  logic bad;
  logic dphWrite;
  logic [dma_seq_pkg::CMD_AW-1:0] dphAddr;
  logic addrPhase;
  logic startCmd;
  logic startOk;
  logic [dma_seq_pkg::BYTES_W-1:0] reqBytes;
  logic [dma_seq_pkg::BYTES_W-1:0] chunk;
  logic [31:0] offs32;
  logic [31:0] statusWord;
  logic fifoEmpty;
  logic rdTake;

  // Command port never stretches a transfer and never errors
  assign hreadyout = 1'b1;
  assign hresp = dma_seq_pkg::HRESP_OKAY;
  assign addrPhase = hsel && hready && (htrans == dma_seq_pkg::HTRANS_NONSEQ ||
                     htrans == (dma_seq_pkg::HTRANS_NONSEQ | 2'h1));

  // Start is taken only when idle and the SRAM write buffer has drained
  assign startCmd = dphWrite && (dphAddr == dma_seq_pkg::CMD_START) &&
                    hwdata[dma_seq_pkg::START_BIT];
  assign reqBytes = sizeBytes(mode, sizeCode);
  assign startOk = startCmd && (state == IDLE) && fifoEmpty && (reqBytes != '0);
  assign chunk = (remain > dma_seq_pkg::DESC_BYTES) ? dma_seq_pkg::DESC_BYTES : remain;
  assign offs32 = {{(32-dma_seq_pkg::BYTES_W){1'b0}}, offset};
  assign busy = (state != IDLE);

  // Status word laid out on the package field positions
  always_comb begin
    statusWord = '0;
    statusWord[dma_seq_pkg::ST_DONE] = done;
    statusWord[dma_seq_pkg::ST_BUSY] = busy;
    statusWord[dma_seq_pkg::ST_BAD] = bad;
  end

  // Address phase capture for the data phase that follows
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dphWrite <= 1'b0;
      dphAddr <= '0;
    end else begin
      dphWrite <= addrPhase && hwrite;
      dphAddr <= haddr[dma_seq_pkg::CMD_AW-1:0];
    end
  end

  // Write commands land in the setup registers only while the sequencer is idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hostAddr <= '0;
      mode <= dma_seq_pkg::DDR_TO_HOST;
      sizeCode <= dma_seq_pkg::SIZE_64K;
    end else if (dphWrite && state == IDLE) begin
      unique case (dphAddr)
        dma_seq_pkg::CMD_HOST_ADDR: hostAddr <= hwdata;
        dma_seq_pkg::CMD_MODE: mode <= dma_seq_pkg::xfer_e'(
            hwdata[dma_seq_pkg::MODE_LSB +: dma_seq_pkg::MODE_W]);
        dma_seq_pkg::CMD_SIZE: sizeCode <= dma_seq_pkg::size_e'(
            hwdata[dma_seq_pkg::SIZE_LSB +: dma_seq_pkg::SIZE_W]);
        default: ;
      endcase
    end
  end

  // Read data is registered at the address phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (addrPhase && !hwrite) begin
      unique case (haddr[dma_seq_pkg::CMD_AW-1:0])
        dma_seq_pkg::CMD_HOST_ADDR: hrdata <= hostAddr;
        dma_seq_pkg::CMD_MODE: hrdata <= 32'(mode);
        dma_seq_pkg::CMD_SIZE: hrdata <= 32'(sizeCode);
        dma_seq_pkg::CMD_STATUS: hrdata <= statusWord;
        dma_seq_pkg::CMD_CYCLES: hrdata <= 32'(cycles);
        default: hrdata <= '0;
      endcase
    end
  end

  // Sequencer: load a descriptor, start, wait, rearm while bytes remain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      remain <= '0;
      offset <= '0;
    end else begin
      unique case (state)
        IDLE: begin
          if (startOk) begin
            remain <= reqBytes;
            offset <= '0;
            state <= LOAD;
          end
        end
        LOAD: state <= KICK;
        KICK: state <= RUN;
        RUN: begin
          // Host reads may stall the engine for long; no timeout is imposed
          if (engDone) begin
            remain <= remain - chunk;
            offset <= offset + chunk;
            state <= (remain > chunk) ? REARM : FINISH;
          end
        end
        REARM: state <= LOAD;
        FINISH: state <= IDLE;
      endcase
    end
  end

  // Descriptor registers load as LOAD ends, on the same edge that raises the start pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      engSrcAddr <= '0;
      engDstAddr <= '0;
      engLength <= '0;
      engMode <= '0;
    end else if (state == LOAD) begin
      engLength <= chunk[dma_seq_pkg::LEN_W-1:0];
      engMode <= mode;
      unique case (mode)
        dma_seq_pkg::DDR_TO_HOST: begin
          engSrcAddr <= DDR_BASE + offs32;
          engDstAddr <= hostAddr + offs32;
        end
        dma_seq_pkg::HOST_TO_DDR: begin
          engSrcAddr <= hostAddr + offs32;
          engDstAddr <= DDR_BASE + offs32;
        end
        dma_seq_pkg::SRAM_TO_DDR: begin
          engSrcAddr <= SRAM_BASE + offs32;
          engDstAddr <= DDR_BASE + offs32;
        end
        dma_seq_pkg::DDR_TO_SRAM: begin
          engSrcAddr <= DDR_BASE + offs32;
          engDstAddr <= SRAM_BASE + offs32;
        end
      endcase
    end
  end

  // Engine start strobe, one cycle, right after the descriptor is loaded
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      engStart <= 1'b0;
    end else begin
      engStart <= (state == LOAD);
    end
  end

  // Descriptor reset strobe, one cycle, only when another chunk must follow
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      engDescReset <= 1'b0;
    end else begin
      engDescReset <= (state == RUN) && engDone && (remain > chunk);
    end
  end

  // Throughput timer on the fabric clock, from first start to final done
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cycles <= '0;
    end else if (startOk) begin
      cycles <= '0;
    end else if (state == KICK || state == RUN || state == REARM || state == LOAD) begin
      if (!(state == LOAD && remain == reqBytes && offset == '0)) begin
        cycles <= cycles + CYCLE_W'(1);
      end
    end
  end

  // Done and bad-size flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      bad <= 1'b0;
    end else begin
      if (state == FINISH) begin
        done <= 1'b1;
      end else if (startOk) begin
        done <= 1'b0;
      end
      if (startCmd && state == IDLE) begin
        bad <= (reqBytes == '0);
      end
    end
  end

  // Fabric SRAM behind a small write buffer
  sram_fifo_if #(.W(FW)) wbuf ();

  sync_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .mclk(mclk),
    .rst(rst),
    .port(wbuf.fifo)
  );

  logic [31:0] sram [dma_seq_pkg::SRAM_BYTES/4];
  logic [dma_seq_pkg::SRAM_AW-1:0] drainAddr;

  // Reads take the single SRAM port first; writes drain when it is free
  assign rdTake = fpRdValid;
  assign fpRdReady = 1'b1;
  assign wbuf.inValid = fpWrValid;
  assign wbuf.inData = {fpWrAddr[dma_seq_pkg::SRAM_AW+1:2], fpWrData};
  assign fpWrReady = wbuf.inReady;
  assign wbuf.outReady = !rdTake;
  assign fifoEmpty = !wbuf.outValid;
  assign drainAddr = wbuf.outData[FW-1:32];

  // SRAM array write from the buffer head
  always_ff @(posedge mclk) begin
    if (wbuf.outValid && wbuf.outReady) begin
      sram[drainAddr] <= wbuf.outData[31:0];
    end
  end

  // SRAM read data, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rdTake) begin
      fpRdData <= sram[fpRdAddr[dma_seq_pkg::SRAM_AW+1:2]];
    end
  end

  // Read data valid strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fpRdDataValid <= 1'b0;
    end else begin
      fpRdDataValid <= rdTake;
    end
  end
endmodule

// *** sim/dma_seq_checker.sv ***
// Port assertions for the DMA sequencer
`timescale 1ns/100ps
module dma_seq_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] engSrcAddr,
  input wire logic [dma_seq_pkg::LEN_W-1:0] engLength,
  input wire logic engDescReset,
  input wire logic engStart,
  input wire logic engDone,
  input wire logic fpRdValid,
  input wire logic fpRdDataValid,
  input wire logic busy,
  input wire logic done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Command port, engine sequencing and SRAM read timing
  bus_okay_a: assert property (hreadyout && hresp == dma_seq_pkg::HRESP_OKAY)
    else $error("command port not ready");
  start_pulse_a: assert property (engStart |=> !engStart)
    else $error("start longer than one cycle");
  start_busy_a: assert property (engStart |-> busy && !done)
    else $error("start while idle or done");
  desc_stable_a: assert property (engStart |=> $stable(engSrcAddr) && $stable(engLength))
    else $error("descriptor moved after start");
  rearm_start_a: assert property (engDescReset |-> ##2 engStart)
    else $error("no restart after descriptor reset");
  done_timing_a: assert property ($rose(done) |-> $past(engDone, 2))
    else $error("done not two cycles after engine finish");
  done_idle_a: assert property (done |-> !busy)
    else $error("done while busy");
  rd_latency_a: assert property (fpRdValid |=> fpRdDataValid)
    else $error("read data late");
  rd_cause_a: assert property (fpRdDataValid |-> $past(fpRdValid))
    else $error("read data without read");
  cover property (engDescReset);
  cover property ($rose(done));
  cover property (fpRdDataValid);
endmodule
bind pcie_ddr_dma_sequencer dma_seq_checker i_dma_seq_checker (.mclk(mclk), .rst(rst),
  .hreadyout(hreadyout), .hresp(hresp), .engSrcAddr(engSrcAddr), .engLength(engLength),
  .engDescReset(engDescReset), .engStart(engStart), .engDone(engDone),
  .fpRdValid(fpRdValid), .fpRdDataValid(fpRdDataValid), .busy(busy), .done(done));

// *** sim/engine_model.sv ***
// Behavioural DMA engine answering each descriptor after a set delay
`timescale 1ns/100ps
module engine_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic engStart,
  input wire logic [31:0] engSrcAddr,
  input wire logic [31:0] engDstAddr,
  input wire logic [dma_seq_pkg::LEN_W-1:0] engLength,
  input wire logic [31:0] delay,
  output logic engDone,
  output int starts,
  output logic [31:0] total,
  output logic [31:0] lastSrc,
  output logic [31:0] lastDst
);
  int cnt;
  // Long delay stands for stalled host reads; finish pulses once per descriptor
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      engDone <= 1'b0;
      starts <= 0;
      total <= 32'h0;
      lastSrc <= 32'h0;
      lastDst <= 32'h0;
    end else if (engStart) begin
      cnt <= delay;
      engDone <= 1'b0;
      starts <= starts + 1;
      total <= total + 32'(engLength);
      lastSrc <= engSrcAddr;
      lastDst <= engDstAddr;
    end else begin
      cnt <= (cnt != 0) ? cnt - 1 : 0;
      engDone <= (cnt == 1);
    end
  end
endmodule

// *** sim/tb_pcie_ddr_dma_sequencer.sv ***
// Self-checking bench for the DMA sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_pcie_ddr_dma_sequencer;
  localparam logic [31:0] HOST = 32'h1234_0000;
  localparam logic [31:0] SRAM = 32'h3000_0000;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, hready = 1, engDone;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, engSrcAddr, engDstAddr, q, q2;
  logic [1:0] htrans = 0, engMode;
  logic hreadyout, hresp, engDescReset, engStart, fpWrReady, fpRdReady, fpRdDataValid;
  logic [dma_seq_pkg::LEN_W-1:0] engLength;
  logic fpWrValid = 0, fpRdValid = 0, busy, done;
  logic [31:0] fpWrAddr = 0, fpWrData = 0, fpRdAddr = 0, fpRdData, total, lastSrc, lastDst;
  int mismatches = 0, cmp_count = 0, cyc = 0, delay = 1, starts;
  pcie_ddr_dma_sequencer i_pcie_ddr_dma_sequencer (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .engSrcAddr(engSrcAddr),
    .engDstAddr(engDstAddr), .engLength(engLength), .engMode(engMode),
    .engDescReset(engDescReset), .engStart(engStart), .engDone(engDone),
    .fpWrValid(fpWrValid), .fpWrAddr(fpWrAddr), .fpWrData(fpWrData), .fpWrReady(fpWrReady),
    .fpRdValid(fpRdValid), .fpRdAddr(fpRdAddr), .fpRdReady(fpRdReady),
    .fpRdDataValid(fpRdDataValid), .fpRdData(fpRdData), .busy(busy), .done(done));
  engine_model i_engine_model (.mclk(mclk), .rst(rst), .engStart(engStart),
    .engSrcAddr(engSrcAddr), .engDstAddr(engDstAddr), .engLength(engLength), .delay(delay),
    .engDone(engDone), .starts(starts), .total(total), .lastSrc(lastSrc), .lastDst(lastDst));
  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One AHB single transfer; read data sampled in the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    {hsel, hwrite, haddr, htrans} = {1'b1, wr, 24'h0, a, dma_seq_pkg::HTRANS_NONSEQ};
    @(negedge mclk);
    {hsel, htrans, hwdata} = {1'b0, 2'h0, d};
    q = hrdata;
  endtask
  // Program and run one transfer, then judge chunks, bytes and status
  task automatic run(input logic [1:0] m, input logic [2:0] s, input logic [31:0] b, int n);
    int s0 = starts;
    logic [31:0] t0 = total;
    ahb(1, dma_seq_pkg::CMD_HOST_ADDR, HOST);
    ahb(1, dma_seq_pkg::CMD_MODE, {30'h0, m});
    ahb(1, dma_seq_pkg::CMD_SIZE, {29'h0, s});
    ahb(1, dma_seq_pkg::CMD_START, 32'h1);
    repeat (2) @(negedge mclk);
    `CHK("busy", 1'b1, busy)
    `CHK("doneclr", 1'b0, done)
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge mclk);
    `CHK("chunks", n, starts - s0)
    `CHK("bytes", b, total - t0)
    `CHK("mode", m, engMode)
    ahb(0, dma_seq_pkg::CMD_STATUS, 32'h0);
    `CHK("status", 32'h1, q)
    ahb(0, dma_seq_pkg::CMD_CYCLES, 32'h0);
    q2 = q;
    ahb(0, dma_seq_pkg::CMD_CYCLES, 32'h0);
    `CHK("cychold", q2, q)
    `CHK("cycmin", 1'b1, q >= n * delay)
    // First chunk costs start plus engine time, each rearm two cycles more
    `CHK("cycexact", n * (delay + 4) - 2, q)
  endtask
  // Reset in mid transfer returns the sequencer to idle with the timer cleared
  task automatic mid_reset;
    ahb(1, dma_seq_pkg::CMD_MODE, 32'h1);
    ahb(1, dma_seq_pkg::CMD_SIZE, 32'h2);
    ahb(1, dma_seq_pkg::CMD_START, 32'h1);
    repeat (20) @(negedge mclk);
    `CHK("midbusy", 1'b1, busy)
    rst = 1;
    repeat (2) @(negedge mclk);
    rst = 0;
    `CHK("mrstbusy", 1'b0, busy)
    `CHK("mrstdone", 1'b0, done)
    `CHK("mrststart", 1'b0, engStart)
    ahb(0, dma_seq_pkg::CMD_CYCLES, 32'h0);
    `CHK("mrstcyc", 32'h0, q)
  endtask
  task automatic sram_wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge mclk);
    {fpWrValid, fpWrAddr, fpWrData} = {1'b1, a, d};
    while (fpWrReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    fpWrValid = 0;
  endtask
  task automatic sram_rd(input logic [31:0] a, input logic [31:0] e);
    @(negedge mclk);
    {fpRdValid, fpRdAddr} = {1'b1, a};
    @(negedge mclk);
    fpRdValid = 0;
    `CHK("rdvalid", 1'b1, fpRdDataValid)
    `CHK("rddata", e, fpRdData)
  endtask
  // Fill the write buffer while reads stall it, then drain and read back
  task automatic sram_test;
    @(negedge mclk);
    {fpRdValid, fpRdAddr} = {1'b1, SRAM + 32'h100};
    for (int i = 0; i < 4; i++) sram_wr(SRAM + 4 * i, 32'hA500 + i);
    `CHK("full", 1'b0, fpWrReady)
    `CHK("rdready", 1'b1, fpRdReady)
    fpRdValid = 0;
    repeat (6) @(negedge mclk);
    `CHK("empty", 1'b1, fpWrReady)
    sram_wr(SRAM + 32'h7FFC, 32'hBEEF);
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 4; i++) sram_rd(SRAM + 4 * i, 32'hA500 + i);
    sram_rd(SRAM + 32'h7FFC, 32'hBEEF);
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst = 0;
    `CHK("rstbusy", 1'b0, busy)
    `CHK("rstdone", 1'b0, done)
    ahb(0, dma_seq_pkg::CMD_CYCLES, 32'h0);
    `CHK("rstcyc", 32'h0, q)
    run(2'h1, 3'h1, 32'h40000, 4);
    `CHK("src", HOST + 32'h30000, lastSrc)
    `CHK("dst", 32'hA003_0000, lastDst)
    delay = 30;
    run(2'h0, 3'h0, 32'h10000, 1);
    run(2'h1, 3'h2, 32'h100000, 16);
    delay = 1;
    run(2'h2, 3'h3, 32'h4000, 1);
    run(2'h3, 3'h4, 32'h8000, 1);
    ahb(1, dma_seq_pkg::CMD_SIZE, 32'h0);
    ahb(1, dma_seq_pkg::CMD_START, 32'h1);
    ahb(0, dma_seq_pkg::CMD_STATUS, 32'h0);
    `CHK("refused", 32'h5, q)
    sram_test();
    mid_reset();
    end_of_test();
  end
endmodule
